/* design/dispatcher_params.svh */
// constants for the reader command dispatcher
`ifndef DISPATCHER_PARAMS_SVH
`define DISPATCHER_PARAMS_SVH
`define OFS_OPERATION   12'h000
`define OFS_BIT_FRAMING 12'h004
`define OFS_FIFO_DATA   12'h008
`define OFS_ERROR       12'h00c
`define OFS_STATUS      12'h010
`define OFS_SELF_TEST   12'h014
`define OP_IDLE         4'h0
`define OP_MEM          4'h1
`define OP_RANDOM       4'h2
`define OP_CRC          4'h3
`define OP_TRANSMIT     4'h4
`define OP_KEEP         4'h7
`define OP_RECEIVE      4'h8
`define OP_TRANSCEIVE   4'hc
`define OP_AUTH         4'he
`define OP_SOFT_RESET   4'hf
`define SELF_TEST_ON    4'h9
`define MEM_BYTES       25
`define RANDOM_BYTES    10
`define AUTH_ARG_BYTES  12
`define SLEEP_BIT       4
`define START_SEND_BIT  7
`define ERR_WRITE_BIT   0
`define COUNT_LSB       16
`endif

/* design/dispatcher_pkg.sv */
// types shared by the reader command dispatcher
package dispatcher_pkg;

  typedef enum logic [9:0] {
    ST_IDLE     = 10'h001,
    ST_MEM_IN   = 10'h002,
    ST_MEM_OUT  = 10'h004,
    ST_RANDOM   = 10'h008,
    ST_CRC      = 10'h010,
    ST_TX       = 10'h020,
    ST_RX       = 10'h040,
    ST_TRX_WAIT = 10'h080,
    ST_AUTH     = 10'h100,
    ST_SRST     = 10'h200
  } state_t;

  typedef struct packed {
    logic tx;
    logic crc;
    logic self_test;
    logic rx;
    logic auth;
    logic auth_start;
  } engine_ctrl_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_in_t;

endpackage : dispatcher_pkg

/* design/reader_command_dispatcher.sv */
// reader command dispatcher: operation state machine, fifo, apb registers
`timescale 1ns/100ps
`include "dispatcher_params.svh"
module reader_command_dispatcher #(
  parameter int FIFO_DEPTH = 64,
  parameter int BUF_BYTES  = 25
) (
  input  wire logic                     core_clk_in,
  input  wire logic                     nrst_in,
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [11:0]              paddr_in,
  input  wire logic [31:0]              pwdata_in,
  output logic                          pready_out,
  output logic [31:0]                   prdata_out,
  output logic                          pslverr_out,
  output logic [7:0]                    stream_data_out,
  output logic                          stream_valid_out,
  input  wire logic                     stream_ready_in,
  input  wire dispatcher_pkg::byte_in_t rx_byte_in,
  input  wire logic                     rx_end_in,
  input  wire logic                     auth_done_in,
  input  wire logic [7:0]               random_byte_in,
  output dispatcher_pkg::engine_ctrl_t  engine_ctrl_out,
  output logic                          sleep_request_out
);

  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  generate
    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0 ||
        BUF_BYTES < `MEM_BYTES || BUF_BYTES > 32) begin : g_bad_params
      $error("fifo depth must be a power of two, buffer 25..32 bytes");
    end
  endgenerate

  dispatcher_pkg::state_t state_q;
  dispatcher_pkg::state_t state_d;
  logic [3:0]    op_code_q;
  logic          sleep_q;
  logic          start_send_q;
  logic          wr_err_q;
  logic [3:0]    self_test_q;
  logic [4:0]    cnt_q;
  logic          ack_q;
  logic [31:0]   prdata_q;
  logic          slverr_q;
  logic          auth_start_q;
  logic [7:0]    fifo_mem_q [FIFO_DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic [7:0]    buf_mem_q [BUF_BYTES];

  // apb decode
  wire sel_op   = paddr_in == `OFS_OPERATION;
  wire sel_frm  = paddr_in == `OFS_BIT_FRAMING;
  wire sel_data = paddr_in == `OFS_FIFO_DATA;
  wire sel_err  = paddr_in == `OFS_ERROR;
  wire sel_stat = paddr_in == `OFS_STATUS;
  wire sel_st   = paddr_in == `OFS_SELF_TEST;
  wire mapped   = sel_op | sel_frm | sel_data | sel_err | sel_stat | sel_st;

  // state decode
  wire st_idle  = state_q == dispatcher_pkg::ST_IDLE;
  wire st_mem_i = state_q == dispatcher_pkg::ST_MEM_IN;
  wire st_mem_o = state_q == dispatcher_pkg::ST_MEM_OUT;
  wire st_rand  = state_q == dispatcher_pkg::ST_RANDOM;
  wire st_crc   = state_q == dispatcher_pkg::ST_CRC;
  wire st_tx    = state_q == dispatcher_pkg::ST_TX;
  wire st_rx    = state_q == dispatcher_pkg::ST_RX;
  wire st_wait  = state_q == dispatcher_pkg::ST_TRX_WAIT;
  wire st_auth  = state_q == dispatcher_pkg::ST_AUTH;
  wire st_srst  = state_q == dispatcher_pkg::ST_SRST;

  wire self_test_on = self_test_q == `SELF_TEST_ON;
  wire transceive   = op_code_q == `OP_TRANSCEIVE;
  wire fifo_empty   = count_q == '0;
  wire fifo_full    = count_q == CW'(FIFO_DEPTH);
  wire auth_args    = st_auth & (cnt_q < 5'(`AUTH_ARG_BYTES));
  wire [7:0] head   = fifo_mem_q[rd_ptr_q];

  // engine side of the fifo
  wire stream_ok = st_tx | (st_crc & ~self_test_on) | auth_args;
  assign stream_valid_out = stream_ok & ~fifo_empty;
  assign stream_data_out  = head;
  wire stream_pop = stream_valid_out & stream_ready_in;
  wire mem_pop    = st_mem_i & ~fifo_empty;
  wire mem_push   = st_mem_o & ~fifo_full;
  wire rx_push    = rx_byte_in.valid & (st_rx | (st_crc & self_test_on)) & ~fifo_full;
  wire eng_pop    = stream_pop | mem_pop;
  wire eng_push   = mem_push | rx_push;
  wire [7:0] eng_data = st_mem_o ? buf_mem_q[cnt_q] : rx_byte_in.data;

  // apb access: fifo data port waits while the engine owns the fifo this cycle
  wire conflict = sel_data & (eng_pop | eng_push);
  wire acc      = psel_in & penable_in & ~ack_q & ~conflict;
  wire wr       = acc & pwrite_in;
  wire rd       = acc & ~pwrite_in;
  wire wr_op    = wr & sel_op;
  wire [3:0] new_code = pwdata_in[3:0];
  wire start_op = wr_op & (new_code != `OP_KEEP);
  wire blocked_hit = acc & sel_data & st_auth;
  wire apb_push = wr & sel_data & ~st_auth & ~fifo_full;
  wire apb_pop  = rd & sel_data & ~st_auth & ~fifo_empty;
  wire push     = eng_push | apb_push;
  wire pop      = eng_pop | apb_pop;
  wire [7:0] push_data = eng_push ? eng_data : pwdata_in[7:0];

  // operation completion
  wire mem_last  = cnt_q == 5'(`MEM_BYTES - 1);
  wire rand_last = cnt_q == 5'(`RANDOM_BYTES - 1);
  wire auth_last = cnt_q == 5'(`AUTH_ARG_BYTES - 1);
  wire go_tx     = st_wait & start_send_q;
  wire step      = mem_pop | mem_push | st_rand | (stream_pop & auth_args);

  function automatic dispatcher_pkg::state_t op_state(input logic [3:0] code,
                                                      input logic       empty);
    case (code)
      `OP_MEM:        op_state = empty ? dispatcher_pkg::ST_MEM_OUT
                                       : dispatcher_pkg::ST_MEM_IN;
      `OP_RANDOM:     op_state = dispatcher_pkg::ST_RANDOM;
      `OP_CRC:        op_state = dispatcher_pkg::ST_CRC;
      `OP_TRANSMIT:   op_state = dispatcher_pkg::ST_TX;
      `OP_RECEIVE:    op_state = dispatcher_pkg::ST_RX;
      `OP_TRANSCEIVE: op_state = dispatcher_pkg::ST_TRX_WAIT;
      `OP_AUTH:       op_state = dispatcher_pkg::ST_AUTH;
      `OP_SOFT_RESET: op_state = dispatcher_pkg::ST_SRST;
      default:        op_state = dispatcher_pkg::ST_IDLE;
    endcase
  endfunction : op_state

  logic done;
  always_comb begin
    state_d = state_q;
    done    = 1'b0;
    case (state_q)
      dispatcher_pkg::ST_IDLE: state_d = state_q;
      dispatcher_pkg::ST_MEM_IN: begin
        done = mem_pop & mem_last;
      end
      dispatcher_pkg::ST_MEM_OUT: begin
        done = mem_push & mem_last;
      end
      dispatcher_pkg::ST_RANDOM: begin
        done = rand_last;
      end
      dispatcher_pkg::ST_CRC: state_d = state_q;
      dispatcher_pkg::ST_TX: begin
        if (fifo_empty) begin
          if (transceive) begin
            state_d = dispatcher_pkg::ST_RX;
          end else begin
            done = 1'b1;
          end
        end
      end
      dispatcher_pkg::ST_RX: begin
        if (rx_end_in) begin
          if (transceive) begin
            state_d = dispatcher_pkg::ST_TRX_WAIT;
          end else begin
            done = 1'b1;
          end
        end
      end
      dispatcher_pkg::ST_TRX_WAIT: begin
        if (go_tx) begin
          state_d = dispatcher_pkg::ST_TX;
        end
      end
      dispatcher_pkg::ST_AUTH: begin
        done = ~auth_args & auth_done_in;
      end
      dispatcher_pkg::ST_SRST: done = 1'b1;
      default: done = 1'b1;
    endcase
    if (done) begin
      state_d = dispatcher_pkg::ST_IDLE;
    end
    // a fresh code wins over whatever was running, except in ST_SRST, where the soft reset returns to ST_IDLE
    if (start_op) begin
      state_d = op_state(new_code, fifo_empty);
    end
  end

  // control registers; soft reset returns them to reset values
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q   <= dispatcher_pkg::ST_IDLE;
      op_code_q <= `OP_IDLE;
      sleep_q   <= 1'b0;
      cnt_q     <= '0;
    end else if (st_srst) begin
      state_q   <= dispatcher_pkg::ST_IDLE;
      op_code_q <= `OP_IDLE;
      sleep_q   <= 1'b0;
      cnt_q     <= '0;
    end else begin
      state_q <= state_d;
      if (start_op) begin
        op_code_q <= new_code;
      end else if (done) begin
        op_code_q <= `OP_IDLE;
      end
      if (wr_op) begin
        sleep_q <= pwdata_in[`SLEEP_BIT];
      end
      if (start_op) begin
        cnt_q <= '0;
      end else if (step) begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      start_send_q <= 1'b0;
      wr_err_q     <= 1'b0;
      self_test_q  <= `OP_IDLE;
      auth_start_q <= 1'b0;
    end else if (st_srst) begin
      start_send_q <= 1'b0;
      wr_err_q     <= 1'b0;
      self_test_q  <= `OP_IDLE;
      auth_start_q <= 1'b0;
    end else begin
      // host write beats the hardware clear
      if (wr & sel_frm) begin
        start_send_q <= pwdata_in[`START_SEND_BIT];
      end else if (go_tx) begin
        start_send_q <= 1'b0;
      end
      // set wins over write-one-to-clear
      if (blocked_hit) begin
        wr_err_q <= 1'b1;
      end else if (wr & sel_err & pwdata_in[`ERR_WRITE_BIT]) begin
        wr_err_q <= 1'b0;
      end
      if (wr & sel_st) begin
        self_test_q <= pwdata_in[3:0];
      end
      auth_start_q <= stream_pop & auth_args & auth_last;
    end
  end

  // fifo pointers; a new operation leaves them alone, except soft reset, which clears them
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else if (st_srst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
      count_q <= count_q + CW'(push) - CW'(pop);
    end
  end

  // storage arrays carry no reset; the buffer survives soft reset
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      fifo_mem_q[wr_ptr_q] <= push_data;
    end
    if (mem_pop) begin
      buf_mem_q[cnt_q] <= head;
    end else if (st_rand) begin
      buf_mem_q[cnt_q] <= random_byte_in;
    end
  end

  // register read data
  wire [31:0] rd_op   = 32'(op_code_q) | (32'(sleep_q) << `SLEEP_BIT);
  wire [31:0] rd_frm  = 32'(start_send_q) << `START_SEND_BIT;
  wire [31:0] rd_data = (st_auth | fifo_empty) ? 32'h0 : 32'(head);
  wire [31:0] rd_err  = 32'(wr_err_q) << `ERR_WRITE_BIT;
  wire [31:0] rd_stat = (32'(count_q) << `COUNT_LSB) | 32'(state_q);
  wire [31:0] rd_st   = 32'(self_test_q);
  wire [31:0] rd_val  = sel_op   ? rd_op   :
                        sel_frm  ? rd_frm  :
                        sel_data ? rd_data :
                        sel_err  ? rd_err  :
                        sel_stat ? rd_stat :
                        sel_st   ? rd_st   : 32'h0;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_q    <= 1'b0;
      prdata_q <= 32'h0;
      slverr_q <= 1'b0;
    end else begin
      ack_q    <= acc;
      slverr_q <= acc & ~mapped;
      if (rd) begin
        prdata_q <= rd_val;
      end
    end
  end

  assign pready_out  = ack_q;
  assign prdata_out  = prdata_q;
  assign pslverr_out = ack_q & slverr_q;

  assign engine_ctrl_out.tx         = st_tx;
  assign engine_ctrl_out.crc        = st_crc & ~self_test_on;
  assign engine_ctrl_out.self_test  = st_crc & self_test_on;
  assign engine_ctrl_out.rx         = st_rx;
  assign engine_ctrl_out.auth       = st_auth & ~auth_args;
  assign engine_ctrl_out.auth_start = auth_start_q;
  assign sleep_request_out          = sleep_q;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  keep_op_code_a: assert property (
    wr_op && new_code == `OP_KEEP |=> op_code_q == $past(op_code_q) || $past(done))
    else $error("keep code changed the operation");

  idle_cancel_a: assert property (
    wr_op && new_code == `OP_IDLE |=> st_idle && op_code_q == `OP_IDLE)
    else $error("idle code did not cancel");

  tx_end_a: assert property (
    st_tx && fifo_empty && !transceive && !start_op |=> st_idle && op_code_q == `OP_IDLE)
    else $error("transmit did not end on empty fifo");

  trx_hold_a: assert property (
    st_wait && !start_send_q |-> !stream_valid_out ##1 (st_wait || start_op || st_idle || $past(start_op)))
    else $error("transceive left wait without start send");

  auth_block_a: assert property (
    blocked_hit |=> wr_err_q && $stable(count_q))
    else $error("fifo access during authentication not flagged");

  crc_stays_a: assert property (
    st_crc && !start_op |=> st_crc [*2] or (st_crc ##1 $past(start_op)))
    else $error("crc operation ended by itself");

  auth_args_a: assert property (
    auth_start_q |-> $past(cnt_q) == 5'(`AUTH_ARG_BYTES - 1) && !auth_args && st_auth)
    else $error("authentication started before all arguments");

  soft_reset_a: assert property (
    st_srst |=> st_idle && op_code_q == `OP_IDLE && count_q == '0 && !wr_err_q)
    else $error("soft reset did not restore registers");

  fifo_keep_a: assert property (
    start_op && !push && !pop |=> count_q == $past(count_q))
    else $error("operation start changed fifo level");

endmodule : reader_command_dispatcher

/* dv/host_apb_master.sv */
// apb host model issuing register transfers to the dispatcher
`timescale 1ns/100ps
module host_apb_master (
  input  wire logic        clk_in,
  input  wire logic        pready_in,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pslverr_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic [11:0]      paddr_out,
  output logic [31:0]      pwdata_out
);
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0000_0000;
  end

  // request held until the pready edge; code 1101 is never issued
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= wr;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    // no cycle limit here: only the bench timeout may end a stalled wait
    do begin
      @(posedge clk_in);
    end while (pready_in !== 1'b1);
    q = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    // released lines show the inverse, not a stale value
    paddr_out <= ~a;
    pwdata_out <= ~d;
  endtask : xfer
endmodule : host_apb_master

/* dv/testbench.sv */
// self-checking bench for the reader command dispatcher
`timescale 1ns/100ps
`include "dispatcher_params.svh"
module testbench;
  logic                         core_clk_in = 1'b0;
  logic                         nrst_in = 1'b0;
  logic                         psel, penable, pwrite, pready, pslverr;
  logic [11:0]                  paddr;
  logic [31:0]                  pwdata, prdata, v;
  logic [7:0]                   sdata;
  logic                         svalid, sleep, e;
  logic                         stream_ready_in = 1'b0;
  dispatcher_pkg::byte_in_t     rx_byte_in = '0;
  logic                         rx_end_in = 1'b0;
  logic                         auth_done_in = 1'b0;
  logic [7:0]                   random_byte_in = 8'h00;
  dispatcher_pkg::engine_ctrl_t ectl;
  logic [31:0]                  rnd = 32'h0000_009e;
  logic                         go = 1'b0;
  int                           err_count = 0;
  int                           n_compared = 0;
  int                           cyc = 0;
  int                           starts = 0;
  logic [7:0]                   model_q[$];
  logic [7:0]                   buf_q[$];

  reader_command_dispatcher dut_u (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr), .stream_data_out(sdata),
    .stream_valid_out(svalid), .stream_ready_in(stream_ready_in), .rx_byte_in(rx_byte_in),
    .rx_end_in(rx_end_in), .auth_done_in(auth_done_in), .random_byte_in(random_byte_in),
    .engine_ctrl_out(ectl), .sleep_request_out(sleep));
  host_apb_master host_u (.clk_in(core_clk_in), .pready_in(pready), .prdata_in(prdata),
    .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata));

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  always #5 core_clk_in = ~core_clk_in;

  // engine stalls at random; every byte the stream pops must be the model's head
  always @(posedge core_clk_in) begin
    rnd <= nxt(rnd);
    stream_ready_in <= go & rnd[3];
    random_byte_in <= rnd[7:0];
    cyc <= cyc + 1;
    if (ectl.auth_start === 1'b1)
      starts <= starts + 1;
    if (svalid === 1'b1 && stream_ready_in === 1'b1)
      chk("stream byte", {24'h0, sdata}, {24'h0, model_q.pop_front()});
    if (cyc == 40000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    host_u.xfer(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    host_u.xfer(1'b0, a, 32'h0, v, e);
  endtask : rd

  // model first: a running stream may pop the byte at the very edge the write returns
  task automatic put(input logic [7:0] b);
    model_q.push_back(b);
    wr(`OFS_FIFO_DATA, {24'h0, b});
  endtask : put

  task automatic pull();
    rd(`OFS_FIFO_DATA);
    chk("fifo read", v, {24'h0, model_q.pop_front()});
  endtask : pull

  task automatic stat(input logic [9:0] s, input string nm);
    rd(`OFS_STATUS);
    chk({nm, " state"}, {22'h0, v[9:0]}, {22'h0, s});
    chk({nm, " count"}, {16'h0, v[31:16]}, model_q.size());
  endtask : stat

  task automatic wait_st(input logic [9:0] s);
    int n;
    n = 0;
    do begin
      rd(`OFS_STATUS);
      n++;
    end while (v[9:0] !== s && n < 100);
  endtask : wait_st

  task automatic op(input logic [7:0] c);
    wr(`OFS_OPERATION, {24'h0, c});
  endtask : op

  task automatic strobe(input int k);
    @(posedge core_clk_in);
    if (k == 0) rx_end_in <= 1'b1;
    else auth_done_in <= 1'b1;
    @(posedge core_clk_in);
    rx_end_in <= 1'b0;
    auth_done_in <= 1'b0;
  endtask : strobe

  task automatic rx_send(input logic [7:0] b);
    @(posedge core_clk_in);
    rx_byte_in <= {1'b1, b};
    model_q.push_back(b);
    @(posedge core_clk_in);
    rx_byte_in <= '0;
  endtask : rx_send

  initial begin
    repeat (20) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    rd(`OFS_OPERATION);
    chk("op reset", v, 32'h0);
    stat(dispatcher_pkg::ST_IDLE, "reset");
    rd(12'h040);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", v, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 3; i++) put(rnd[15:8]);
    op(`OP_TRANSMIT);
    stat(dispatcher_pkg::ST_TX, "tx held");
    chk("tx ctrl", ectl.tx, 1);
    go <= 1'b1;
    wait_st(dispatcher_pkg::ST_IDLE);
    stat(dispatcher_pkg::ST_IDLE, "tx end");
    rd(`OFS_OPERATION);
    chk("tx code", v, 0);
    $display("test transmit done");
    put(8'h5a);
    op(`OP_CRC);
    put(8'ha5);
    repeat (40) @(posedge core_clk_in);
    stat(dispatcher_pkg::ST_CRC, "crc");
    chk("crc ctrl", ectl.crc, 1);
    op(8'h17);
    chk("sleep", sleep, 1);
    rd(`OFS_OPERATION);
    chk("keep code", v, 32'h13);
    op(`OP_IDLE);
    stat(dispatcher_pkg::ST_IDLE, "crc stop");
    wr(`OFS_SELF_TEST, 32'h9);
    op(`OP_CRC);
    chk("self test", ectl.self_test, 1);
    op(`OP_IDLE);
    wr(`OFS_SELF_TEST, 32'h0);
    $display("test crc done");
    op(`OP_RECEIVE);
    chk("rx ctrl", ectl.rx, 1);
    for (int i = 0; i < 3; i++) rx_send(rnd[23:16]);
    stat(dispatcher_pkg::ST_RX, "rx");
    op(8'h05);
    stat(dispatcher_pkg::ST_IDLE, "unknown");
    for (int i = 0; i < 3; i++) pull();
    $display("test receive done");
    put(8'h11);
    put(8'h22);
    op(`OP_TRANSCEIVE);
    repeat (8) @(posedge core_clk_in);
    stat(dispatcher_pkg::ST_TRX_WAIT, "trx wait");
    wr(`OFS_BIT_FRAMING, 32'h80);
    wait_st(dispatcher_pkg::ST_RX);
    stat(dispatcher_pkg::ST_RX, "trx rx");
    rx_send(8'h3c);
    strobe(0);
    wait_st(dispatcher_pkg::ST_TRX_WAIT);
    stat(dispatcher_pkg::ST_TRX_WAIT, "trx again");
    op(`OP_IDLE);
    pull();
    $display("test transceive done");
    for (int i = 0; i < 11; i++) put(rnd[7:0]);
    op(`OP_AUTH);
    repeat (80) @(posedge core_clk_in);
    strobe(1);
    stat(dispatcher_pkg::ST_AUTH, "auth short");
    chk("auth early", starts, 0);
    wr(`OFS_FIFO_DATA, 32'h77);
    rd(`OFS_ERROR);
    chk("auth block", v[0], 1);
    wr(`OFS_ERROR, 32'h1);
    rd(`OFS_ERROR);
    chk("err clear", v[0], 0);
    op(`OP_IDLE);
    for (int i = 0; i < 12; i++) put(rnd[7:0]);
    op(`OP_AUTH);
    repeat (80) @(posedge core_clk_in);
    chk("auth ctrl", ectl.auth, 1);
    chk("auth start", starts, 1);
    strobe(1);
    wait_st(dispatcher_pkg::ST_IDLE);
    stat(dispatcher_pkg::ST_IDLE, "auth end");
    $display("test auth done");
    for (int i = 0; i < 25; i++) put(rnd[31:24]);
    op(`OP_MEM);
    wait_st(dispatcher_pkg::ST_IDLE);
    buf_q = model_q;
    model_q.delete();
    stat(dispatcher_pkg::ST_IDLE, "mem store");
    op(8'h10);
    // sleep bit written high by the same write, so only the reset can clear it
    op(8'h1f);
    wait_st(dispatcher_pkg::ST_IDLE);
    chk("srst sleep", sleep, 0);
    op(`OP_MEM);
    wait_st(dispatcher_pkg::ST_IDLE);
    model_q = buf_q;
    stat(dispatcher_pkg::ST_IDLE, "mem load");
    for (int i = 0; i < 25; i++) pull();
    op(`OP_RANDOM);
    wait_st(dispatcher_pkg::ST_IDLE);
    rd(`OFS_OPERATION);
    chk("random code", v, 0);
    $display("test buffer done");
    report_and_stop();
  end
endmodule : testbench
